// >>> rxgc_top.sv
// rxgc_top: receive gain compensation and slicer for four receivers, with an
// Avalon-MM register slave. assumes samples and gain indices come from logic on CLK_SYS_IN.
//
// Overview of operation
// RL1 - with compensation on, digital gain equals front-end attenuation so the path gain is 0 dB.
// RL2 - the digital gain comes from the gain table, each index holding an attenuator setting and a gain.
// RL3 - the compensating gain is clamped at 50 dB.
// RL4 - after reset the block runs in no-compensation mode.
// RL5 - without compensation the slicer is bypassed and unwidened 12, 16 or 24 bit words go to the link.
// RL6 - without compensation the gain stage may only trim the table steps, by default to even 0.5 dB.
// RL7 - from a 16 bit input, every 6 dB of gain widens the sample by one bit.
// RL8 - the slicer keeps the 16 MSBs of the widened sample and drops the excess LSBs.
// RL9 - at 6 dB of slicing the code is 0001 with one LSB dropped, at 12 dB two LSBs are dropped.
// RL10 - the slicer step is selectable as 1, 2, 3, 4, 6 or 8 dB.
// RL11 - the slicer sits at code 0000 while no gain is applied.
// RL12 - in compensation mode the position goes out on four lines per receiver as soon as it changes.
// RL13 - receivers 1 to 4 drive lines 11..8, 15..12, 7..4 and 3..0, MSB first.
// RL14 - software must enable those lines as outputs and select the slicer function on them.
// RL15 - with 6 dB steps the code is 0 at zero gain, 1 below 6 dB, then one more per 6 dB up to 9 at 50 dB.
// RL16 - compensation works with the gain index from the AGC or from the manual index register.
// RL17 - other steps band the same way scaled by the step, saturating at the code for 50 dB; the code caps at 15 (POS_MAX), short of it for 1-3 dB steps.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
module rxgc_top #(
  parameter int TABLE_DEPTH = 256
) (
  // clock and reset
  input  wire logic                                    CLK_SYS_IN,
  input  wire logic                                    RST_IN,
  // avalon-mm slave
  input  wire logic [7:0]                              AVS_ADDRESS_IN,
  input  wire logic                                    AVS_READ_IN,
  input  wire logic                                    AVS_WRITE_IN,
  input  wire logic [31:0]                             AVS_WRITEDATA_IN,
  input  wire logic [3:0]                              AVS_BYTEENABLE_IN,
  output logic      [31:0]                             AVS_READDATA_OUT,
  output logic                                         AVS_WAITREQUEST_OUT,
  // receive samples from the front end
  input  wire logic [rxgc_pkg::RX_NUM*rxgc_pkg::IN_W-1:0]  RX_SAMPLE_IN,
  input  wire logic [rxgc_pkg::RX_NUM-1:0]                 RX_VALID_IN,
  input  wire logic [rxgc_pkg::RX_NUM*rxgc_pkg::IDX_W-1:0] AGC_GAIN_INDEX_IN,
  // front-end attenuator settings
  output logic      [rxgc_pkg::RX_NUM*rxgc_pkg::ATT_W-1:0] ATTEN_SETTING_OUT,
  // link words
  output logic      [rxgc_pkg::RX_NUM*rxgc_pkg::LINK_W-1:0] LINK_SAMPLE_OUT,
  output logic      [rxgc_pkg::RX_NUM-1:0]                  LINK_VALID_OUT,
  // slicer position lines
  output logic      [15:0]                             GPIO_OUT,
  output logic      [15:0]                             GPIO_OE_OUT
);
  import rxgc_pkg::*;

  localparam int TAB_W = GAIN_W + ATT_W;

  // byte-lane merge used by every writable register
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    be_merge = r;
  endfunction : be_merge

  // register state
  logic [31:0]      ctrl_reg;
  logic [31:0]      gain_src_reg;
  logic [31:0]      man_index_reg;
  logic [31:0]      gpio_cfg_reg;
  logic [IDX_W-1:0] table_addr_reg;
  logic [TAB_W-1:0] table_mem [TABLE_DEPTH];
  logic             ack_reg;
  logic [31:0]      readdata_reg;

  // bus decode
  wire              access      = AVS_READ_IN | AVS_WRITE_IN;
  wire              wr_commit   = AVS_WRITE_IN & ack_reg;
  wire              hit_ctrl    = (AVS_ADDRESS_IN == REG_CTRL);
  wire              hit_src     = (AVS_ADDRESS_IN == REG_GAIN_SRC);
  wire              hit_man     = (AVS_ADDRESS_IN == REG_MAN_INDEX);
  wire              hit_gpio    = (AVS_ADDRESS_IN == REG_GPIO_CFG);
  wire              hit_status  = (AVS_ADDRESS_IN == REG_STATUS);
  wire              hit_taddr   = (AVS_ADDRESS_IN == REG_TABLE_ADDR);
  wire              hit_tdata   = (AVS_ADDRESS_IN == REG_TABLE_DATA);
  wire              tab_in_range = (32'(table_addr_reg) < 32'(TABLE_DEPTH));
  wire [31:0]       tdata_merged;
  wire [31:0]       taddr_merged;
  wire [31:0]       tab_word;
  wire [31:0]       status_word;
  logic [31:0]      rd_mux;

  // configuration views
  wire rxgc_mode_e  mode      = rxgc_mode_e'(ctrl_reg[CTRL_MODE_BIT]);
  wire rxgc_width_e link_fmt  = rxgc_width_e'(ctrl_reg[CTRL_WIDTH_LSB +: 2]);
  wire [2:0]        step_sel  = ctrl_reg[CTRL_STEP_LSB +: 3];
  wire              comp_on   = (mode == RXGC_MODE_SLICER);

  // per receiver
  logic [IDX_W-1:0]      idx      [RX_NUM];
  logic [TAB_W-1:0]      entry    [RX_NUM];
  logic [GAIN_W-1:0]     tab_gain [RX_NUM];
  logic [GAIN_W-1:0]     gain_reg [RX_NUM];
  logic [ATT_W-1:0]      att_reg  [RX_NUM];
  logic [LINK_W-1:0]     word_next[RX_NUM];
  logic [LINK_W-1:0]     word_reg [RX_NUM];
  logic                  lvalid_next [RX_NUM];
  logic                  lvalid_reg  [RX_NUM];
  logic [POS_W-1:0]      pos_w    [RX_NUM];
  logic [15:0]           gpio_code;

  assign AVS_WAITREQUEST_OUT = access & ~ack_reg;
  assign AVS_READDATA_OUT    = readdata_reg;
  assign tdata_merged = be_merge(tab_word, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
  assign taddr_merged = be_merge({24'h00_0000, table_addr_reg}, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
  assign tab_word     = tab_in_range ? 32'(table_mem[table_addr_reg]) : 32'h0000_0000;
  assign status_word  = {16'h0000, pos_w[3], pos_w[2], pos_w[1], pos_w[0]};

  always_comb begin
    if (hit_ctrl) begin
      rd_mux = ctrl_reg;
    end else if (hit_src) begin
      rd_mux = gain_src_reg;
    end else if (hit_man) begin
      rd_mux = man_index_reg;
    end else if (hit_gpio) begin
      rd_mux = gpio_cfg_reg;
    end else if (hit_status) begin
      rd_mux = status_word;
    end else if (hit_taddr) begin
      rd_mux = {24'h00_0000, table_addr_reg};
    end else if (hit_tdata) begin
      rd_mux = tab_word;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // one wait state per access; readdata is registered while waitrequest is high
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (AVS_READ_IN & ~ack_reg) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_reg       <= CTRL_RST; // RL4
      gain_src_reg   <= GAIN_SRC_RST;
      man_index_reg  <= MAN_INDEX_RST;
      gpio_cfg_reg   <= GPIO_CFG_RST;
      table_addr_reg <= '0;
    end else if (wr_commit) begin
      if (hit_ctrl) begin
        ctrl_reg <= be_merge(ctrl_reg, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN) & 32'h0000_007f;
      end
      if (hit_src) begin
        gain_src_reg <= be_merge(gain_src_reg, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN) & 32'h0000_000f;
      end
      if (hit_man) begin
        man_index_reg <= be_merge(man_index_reg, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
      end
      if (hit_gpio) begin
        gpio_cfg_reg <= be_merge(gpio_cfg_reg, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
      end
      if (hit_taddr) begin
        table_addr_reg <= taddr_merged[IDX_W-1:0];
      end
    end
  end

  // gain table: flip-flop storage, no reset so it maps to plain registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (wr_commit && hit_tdata && tab_in_range) begin
      table_mem[table_addr_reg] <= tdata_merged[TAB_W-1:0]; // RL2
    end
  end

  for (genvar r = 0; r < RX_NUM; r++) begin : g_rx
    rxgc_path_if path ();

    // index from the AGC or from software
    assign idx[r]      = gain_src_reg[r] ? man_index_reg[IDX_W*r +: IDX_W]
                                         : AGC_GAIN_INDEX_IN[IDX_W*r +: IDX_W]; // RL16
    assign entry[r]    = (32'(idx[r]) < 32'(TABLE_DEPTH)) ? table_mem[idx[r]] : '0;
    assign tab_gain[r] = entry[r][TAB_GAIN_LSB +: GAIN_W];

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
        gain_reg[r] <= '0;
        att_reg[r]  <= '0;
      end else begin
        // gain tracks attenuation one for one; anything past the limit is not compensated
        gain_reg[r] <= (tab_gain[r] > GAIN_MAX_HALF_DB) ? GAIN_MAX_HALF_DB : tab_gain[r]; // RL3
        att_reg[r]  <= entry[r][TAB_ATT_LSB +: ATT_W]; // RL1
      end
    end

    // without compensation only the sub-6dB trim is seen, so no widening happens
    assign path.sample       = RX_SAMPLE_IN[IN_W*r +: IN_W];
    assign path.sample_valid = RX_VALID_IN[r];
    assign path.gain         = comp_on ? gain_reg[r]
                                       : GAIN_W'(gain_reg[r] % HALF_DB_PER_BIT); // RL6
    assign path.step         = step_sel;
    assign pos_w[r]          = comp_on ? path.pos : '0;

    rxgc_gain_stage u_gain (
      .clk_in (CLK_SYS_IN),
      .rst_in (RST_IN),
      .p      (path.gain_stage)
    );

    rxgc_slicer u_slice (
      .clk_in (CLK_SYS_IN),
      .rst_in (RST_IN),
      .p      (path.slicer)
    );

    // link word: slicer bypassed in no-compensation mode
    always_comb begin
      if (comp_on) begin
        word_next[r]   = LINK_W'(path.sliced); // RL8
        lvalid_next[r] = path.sliced_valid;
      end else begin
        lvalid_next[r] = path.wide_valid; // RL5
        case (link_fmt)
          RXGC_W12: word_next[r] = LINK_W'($signed(path.narrow[IN_W-1:4]));
          RXGC_W24: word_next[r] = {path.narrow, 8'h00};
          default:  word_next[r] = LINK_W'(path.narrow);
        endcase
      end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
        word_reg[r]   <= '0;
        lvalid_reg[r] <= 1'b0;
      end else begin
        lvalid_reg[r] <= lvalid_next[r];
        if (lvalid_next[r]) begin
          word_reg[r] <= word_next[r];
        end
      end
    end

    assign LINK_SAMPLE_OUT[LINK_W*r +: LINK_W] = word_reg[r];
    assign LINK_VALID_OUT[r]                   = lvalid_reg[r];
    assign ATTEN_SETTING_OUT[ATT_W*r +: ATT_W] = att_reg[r];
  end

  // receivers 1..4 own lines 11:8, 15:12, 7:4, 3:0
  assign gpio_code = {pos_w[1], pos_w[0], pos_w[2], pos_w[3]}; // RL13

  // a line carries the code only when software selected it; its enable goes out on GPIO_OE_OUT alone
  logic [15:0] gpio_reg;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      gpio_reg <= 16'h0000;
    end else begin
      gpio_reg <= gpio_code & gpio_cfg_reg[GPIO_FUNC_LSB +: 16]; // RL12
    end
  end

  assign GPIO_OUT    = gpio_reg;
  assign GPIO_OE_OUT = gpio_cfg_reg[15:0]; // RL14
endmodule : rxgc_top

// >>> rxgc_pkg.sv
// rxgc_pkg: constants, register map and shared helpers for the receive gain
// compensation and slicer block; imported by every rxgc module except rxgc_bb_model.
package rxgc_pkg;

  // datapath shape
  localparam int RX_NUM   = 4;
  localparam int IN_W     = 16;
  localparam int WIDE_W   = 26;
  localparam int LINK_W   = 24;
  localparam int IDX_W    = 8;
  localparam int GAIN_W   = 7;
  localparam int ATT_W    = 8;
  localparam int POS_W    = 4;
  localparam int MANT_W   = 16;
  localparam int MANT_FRAC = 14;

  // gains are held in half-dB units
  localparam int                GAIN_MAX_DB       = 50;
  localparam logic [GAIN_W-1:0] GAIN_MAX_HALF_DB  = GAIN_W'(2 * GAIN_MAX_DB);
  localparam logic [GAIN_W-1:0] HALF_DB_PER_BIT   = 7'h0c;
  localparam logic [POS_W-1:0]  POS_MAX           = 4'hf;
  localparam logic [3:0]        DROP_MAX          = 4'(WIDE_W - IN_W);

  // register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_GAIN_SRC   = 8'h04;
  localparam logic [7:0] REG_MAN_INDEX  = 8'h08;
  localparam logic [7:0] REG_GPIO_CFG   = 8'h0c;
  localparam logic [7:0] REG_STATUS     = 8'h10;
  localparam logic [7:0] REG_TABLE_ADDR = 8'h14;
  localparam logic [7:0] REG_TABLE_DATA = 8'h18;

  // field positions
  localparam int CTRL_MODE_BIT   = 0;
  localparam int CTRL_WIDTH_LSB  = 1;
  localparam int CTRL_STEP_LSB   = 4;
  localparam int TAB_ATT_LSB     = 0;
  localparam int TAB_GAIN_LSB    = 8;
  localparam int GPIO_FUNC_LSB   = 16;

  // reset values
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] GAIN_SRC_RST  = 32'h0000_0000;
  localparam logic [31:0] MAN_INDEX_RST = 32'h0000_0000;
  localparam logic [31:0] GPIO_CFG_RST  = 32'h0000_0000;

  typedef enum logic {
    RXGC_MODE_NOCOMP = 1'b0,
    RXGC_MODE_SLICER = 1'b1
  } rxgc_mode_e;

  typedef enum logic [1:0] {
    RXGC_W12 = 2'h0,
    RXGC_W16 = 2'h1,
    RXGC_W24 = 2'h2
  } rxgc_width_e;

  typedef enum logic [2:0] {
    RXGC_STEP_1DB = 3'h0,
    RXGC_STEP_2DB = 3'h1,
    RXGC_STEP_3DB = 3'h2,
    RXGC_STEP_4DB = 3'h3,
    RXGC_STEP_6DB = 3'h4,
    RXGC_STEP_8DB = 3'h5
  } rxgc_step_e;

  // 10^(k*0.5/20) in Q2.14 for the sub-6dB part of the gain
  function automatic logic [MANT_W-1:0] rxgc_frac_mant(input logic [3:0] k);
    case (k)
      4'h0:    rxgc_frac_mant = 16'h4000;
      4'h1:    rxgc_frac_mant = 16'h43cb;
      4'h2:    rxgc_frac_mant = 16'h47cf;
      4'h3:    rxgc_frac_mant = 16'h4c10;
      4'h4:    rxgc_frac_mant = 16'h5092;
      4'h5:    rxgc_frac_mant = 16'h5558;
      4'h6:    rxgc_frac_mant = 16'h5a67;
      4'h7:    rxgc_frac_mant = 16'h5fc2;
      4'h8:    rxgc_frac_mant = 16'h656f;
      4'h9:    rxgc_frac_mant = 16'h6b71;
      4'ha:    rxgc_frac_mant = 16'h71cf;
      4'hb:    rxgc_frac_mant = 16'h788e;
      default: rxgc_frac_mant = 16'h4000;
    endcase
  endfunction : rxgc_frac_mant

  // slicer step in half-dB units; unknown codes fall back to 6 dB
  function automatic logic [GAIN_W-1:0] rxgc_step_half_db(input logic [2:0] s);
    case (s)
      RXGC_STEP_1DB: rxgc_step_half_db = 7'h02;
      RXGC_STEP_2DB: rxgc_step_half_db = 7'h04;
      RXGC_STEP_3DB: rxgc_step_half_db = 7'h06;
      RXGC_STEP_4DB: rxgc_step_half_db = 7'h08;
      RXGC_STEP_8DB: rxgc_step_half_db = 7'h10;
      default:       rxgc_step_half_db = 7'h0c;
    endcase
  endfunction : rxgc_step_half_db

endpackage : rxgc_pkg

// >>> rxgc_path_if.sv
// rxgc_path_if: one receiver's path between the top, the gain stage and the slicer.
// assumes all three run on the same system clock.
`timescale 1ns/10ps
interface rxgc_path_if;
  import rxgc_pkg::*;
  logic signed [IN_W-1:0]   sample;
  logic                     sample_valid;
  logic        [GAIN_W-1:0] gain;
  logic        [2:0]        step;
  logic signed [WIDE_W-1:0] wide;
  logic signed [IN_W-1:0]   narrow;
  logic                     wide_valid;
  logic        [POS_W-1:0]  pos;
  logic signed [IN_W-1:0]   sliced;
  logic                     sliced_valid;

  modport top   (output sample, sample_valid, gain, step,
                 input  narrow, wide_valid, pos, sliced, sliced_valid);
  modport gain_stage (input sample, sample_valid, gain, output wide, narrow, wide_valid);
  modport slicer (input wide, wide_valid, gain, step, output pos, sliced, sliced_valid);
endinterface : rxgc_path_if

// >>> rxgc_gain_stage.sv
// rxgc_gain_stage: applies the table's digital gain to one receiver's samples.
// assumes gain is already clamped to the compensation limit by the top.
`timescale 1ns/10ps
module rxgc_gain_stage (
  // clock and reset
  input wire logic   clk_in,
  input wire logic   rst_in,
  // path
  rxgc_path_if.gain_stage p
);
  import rxgc_pkg::*;

  logic        [3:0]        whole_bits;
  logic        [3:0]        frac_k;
  logic signed [32:0]       prod;
  logic signed [32:0]       scaled;
  logic signed [32:0]       widened;
  logic signed [IN_W-1:0]   narrow_sat;
  logic signed [WIDE_W-1:0] wide_reg;
  logic signed [IN_W-1:0]   narrow_reg;
  logic                     valid_reg;

  // whole 6 dB steps become shifts, the remainder a small multiply
  assign whole_bits = 4'(p.gain / HALF_DB_PER_BIT); // RL7
  assign frac_k     = 4'(p.gain % HALF_DB_PER_BIT); // RL6
  assign prod       = 33'($signed(p.sample) * $signed({1'b0, rxgc_frac_mant(frac_k)}));
  assign scaled     = prod >>> MANT_FRAC;
  assign widened    = scaled <<< whole_bits; // RL7

  // unwidened path saturates: only the sub-6dB trim is applied there
  assign narrow_sat = (scaled > 33'sh0_0000_7fff) ? 16'sh7fff :
                      (scaled < -33'sh0_0000_8000) ? -16'sh8000 : scaled[IN_W-1:0];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wide_reg   <= '0;
      narrow_reg <= '0;
      valid_reg  <= 1'b0;
    end else begin
      valid_reg <= p.sample_valid;
      if (p.sample_valid) begin
        wide_reg   <= widened[WIDE_W-1:0];
        narrow_reg <= narrow_sat;
      end
    end
  end

  assign p.wide       = wide_reg;
  assign p.narrow     = narrow_reg;
  assign p.wide_valid = valid_reg;
endmodule : rxgc_gain_stage

// >>> rxgc_slicer.sv
// rxgc_slicer: picks the 16 MSBs of a widened sample and reports the position code.
// assumes gain and wide come from the same receiver path.
`timescale 1ns/10ps
module rxgc_slicer (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // path
  rxgc_path_if.slicer p
);
  import rxgc_pkg::*;

  logic [GAIN_W-1:0] step_h;
  logic [GAIN_W-1:0] band;
  logic [POS_W-1:0]  pos_next;
  logic [7:0]        atten_h;
  logic [3:0]        drop_raw;
  logic [3:0]        drop;
  logic signed [WIDE_W-1:0] shifted;
  logic [POS_W-1:0]  pos_reg;
  logic signed [IN_W-1:0] sliced_reg;
  logic              valid_reg;

  assign step_h   = rxgc_step_half_db(p.step); // RL10
  assign band     = GAIN_W'(p.gain / step_h);
  // zero gain keeps code 0; any gain moves to band+1, saturating
  assign pos_next = (p.gain == '0) ? '0 : // RL11
                    (band >= GAIN_W'(POS_MAX)) ? POS_MAX : // RL17
                    POS_W'(band + 7'h01); // RL15
  // drop enough LSBs to cover the reported attenuation, rounded up to whole bits
  assign atten_h  = 8'(pos_reg * step_h);
  assign drop_raw = 4'((atten_h + 8'(HALF_DB_PER_BIT - 7'h01)) / 8'(HALF_DB_PER_BIT)); // RL9
  assign drop     = (drop_raw > DROP_MAX) ? DROP_MAX : drop_raw;
  assign shifted  = p.wide >>> drop; // RL8

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pos_reg    <= '0;
      sliced_reg <= '0;
      valid_reg  <= 1'b0;
    end else begin
      pos_reg   <= pos_next; // RL12
      valid_reg <= p.wide_valid;
      if (p.wide_valid) begin
        sliced_reg <= shifted[IN_W-1:0]; // RL8
      end
    end
  end

  assign p.pos          = pos_reg;
  assign p.sliced       = sliced_reg;
  assign p.sliced_valid = valid_reg;
endmodule : rxgc_slicer

// >>> rxgc_top_chk.sv
// rxgc_top_chk: port-level timing checks for rxgc_top.
// assumes full-lane register writes and one clock domain.
`timescale 1ns/10ps
module rxgc_top_chk import rxgc_pkg::*; (
  // clock, reset and bus
  input wire logic        CLK_SYS_IN, RST_IN, AVS_READ_IN, AVS_WRITE_IN, AVS_WAITREQUEST_OUT,
  input wire logic [7:0]  AVS_ADDRESS_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN, AGC_GAIN_INDEX_IN,
  // stream and lines
  input wire logic [3:0]  RX_VALID_IN, LINK_VALID_OUT,
  input wire logic [15:0] GPIO_OUT, GPIO_OE_OUT
);
  logic        wr_ok;
  logic        mode_reg;
  logic [15:0] func_reg;
  logic [2:0]  quiet_reg;
  assign wr_ok = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
  // quiet counts edges with no index change and no register write
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_reg  <= 1'b0;
      func_reg  <= 16'h0;
      quiet_reg <= 3'h0;
    end else begin
      if (wr_ok && AVS_ADDRESS_IN == REG_CTRL) mode_reg <= AVS_WRITEDATA_IN[CTRL_MODE_BIT];
      if (wr_ok && AVS_ADDRESS_IN == REG_GPIO_CFG) func_reg <= AVS_WRITEDATA_IN[31:16];
      if (wr_ok || AGC_GAIN_INDEX_IN != $past(AGC_GAIN_INDEX_IN)) quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
    end
  end
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  a_wait_one: assert property ($rose(AVS_READ_IN | AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
    else $error("bus answer not after one wait state");
  a_reset_quiet: assert property ($fell(RST_IN) |-> LINK_VALID_OUT == 4'h0 && GPIO_OUT == 16'h0)
    else $error("outputs active after reset");
  a_lat_nocomp: assert property (!mode_reg && RX_VALID_IN[0] |-> ##2 LINK_VALID_OUT[0])
    else $error("bypass word late");
  a_lat_slice: assert property (mode_reg && RX_VALID_IN[3] |-> ##3 LINK_VALID_OUT[3])
    else $error("sliced word late");
  a_no_spurious: assert property (LINK_VALID_OUT[1] |-> $past(RX_VALID_IN[1], 2) || $past(RX_VALID_IN[1], 3))
    else $error("link word without sample");
  a_oe_write: assert property (wr_ok && AVS_ADDRESS_IN == REG_GPIO_CFG |=> GPIO_OE_OUT == $past(AVS_WRITEDATA_IN[15:0]))
    else $error("line enables not written");
  a_gpio_mask: assert property ((GPIO_OUT & ~(func_reg | $past(func_reg))) == 16'h0)
    else $error("code on unselected line");
  a_gpio_quiet: assert property (quiet_reg == 3'h7 |-> $stable(GPIO_OUT))
    else $error("code moved without cause");
endmodule : rxgc_top_chk
bind rxgc_top rxgc_top_chk u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AGC_GAIN_INDEX_IN(AGC_GAIN_INDEX_IN), .RX_VALID_IN(RX_VALID_IN),
  .LINK_VALID_OUT(LINK_VALID_OUT), .GPIO_OUT(GPIO_OUT), .GPIO_OE_OUT(GPIO_OE_OUT));

// >>> rxgc_bb_model.sv
// rxgc_bb_model: far-side sink keeping the last link word and reading the slicer lines.
// assumes one-cycle valid pulses on the system clock.
`timescale 1ns/10ps
module rxgc_bb_model (
  input  wire logic        clk_in,
  input  wire logic [95:0] link_in,
  input  wire logic [3:0]  valid_in,
  input  wire logic [15:0] gpio_in,
  output logic      [23:0] word_out [4],
  output logic      [3:0]  code_out [4]
);
  // codes are read at once; they run ahead of the words
  assign code_out = '{gpio_in[11:8], gpio_in[15:12], gpio_in[7:4], gpio_in[3:0]};
  always @(posedge clk_in) begin
    for (int r = 0; r < 4; r++) if (valid_in[r]) word_out[r] <= link_in[24*r +: 24];
  end
endmodule : rxgc_bb_model

// >>> tb_rxgc_top.sv
// tb_rxgc_top: self-checking bench for rxgc_top with a far-side sink.
// assumes the far side only listens; the bus master waits for waitrequest low.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_rxgc_top;
  import rxgc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wreq;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0, idx = 32'h0, rdata, att, q;
  logic [63:0] smp = 64'h0;
  logic [3:0]  vld = 4'h0, lvld;
  logic [95:0] link;
  logic [15:0] gpio, oe;
  logic [23:0] word [4];
  logic [3:0]  code [4];
  int          num_errors = 0, n_checks = 0, cyc = 0;
  rxgc_top u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wreq), .RX_SAMPLE_IN(smp), .RX_VALID_IN(vld), .AGC_GAIN_INDEX_IN(idx),
    .ATTEN_SETTING_OUT(att), .LINK_SAMPLE_OUT(link), .LINK_VALID_OUT(lvld), .GPIO_OUT(gpio),
    .GPIO_OE_OUT(oe));
  rxgc_bb_model u_bb (.clk_in(clk), .link_in(link), .valid_in(lvld), .gpio_in(gpio),
    .word_out(word), .code_out(code));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // the request is held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= w;
    rd   <= ~w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic tab(input logic [7:0] i, input logic [7:0] at, input logic [6:0] g);
    bus(1'b1, REG_TABLE_ADDR, {24'h0, i});
    bus(1'b1, REG_TABLE_DATA, {17'h0, g, at});
  endtask : tab
  task automatic send(input logic [63:0] s);
    int t;
    t = 0;
    @(posedge clk);
    smp <= s;
    vld <= 4'hf;
    @(posedge clk);
    vld <= 4'h0;
    do @(negedge clk); while (lvld[0] !== 1'b1 && ++t < 8);
    `CHK("lvalid", 4'hf, lvld)
    @(negedge clk);
  endtask : send
  task automatic t_reset;
    bus(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl", CTRL_RST, q)
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("status", 32'h0, q)
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("oe", GPIO_CFG_RST[15:0], oe)
  endtask : t_reset
  task automatic t_nocomp;
    logic [23:0] e [3];
    e = '{24'hfff842, 24'hff8421, 24'h842100};
    tab(8'h00, 8'h11, 7'h00);
    for (int w = 0; w < 3; w++) begin
      bus(1'b1, REG_CTRL, 32'(w) << CTRL_WIDTH_LSB);
      send({4{16'h8421}});
      `CHK("word", e[w], word[2])
    end
    `CHK("atten", 8'h11, att[7:0])
    tab(8'h01, 8'h22, 7'd13);
    idx <= 32'h01010101;
    send({4{16'h4000}});
    // only the half-dB remainder applies: 0x4000 * 1.0593
    `CHK("trim", 24'h43cb00, word[1])
    `CHK("atten", 8'h22, att[15:8])
  endtask : t_nocomp
  task automatic t_slice;
    logic [6:0] st [6];
    logic [6:0] gs [6];
    logic [6:0] gc;
    logic [3:0] p;
    st = '{7'd2, 7'd4, 7'd6, 7'd8, 7'd12, 7'd16};
    gs = '{7'd0, 7'd1, 7'd12, 7'd13, 7'd100, 7'd120};
    bus(1'b1, REG_GPIO_CFG, 32'hffff_ffff);
    @(negedge clk);
    `CHK("oe", 16'hffff, oe)
    for (int s = 0; s < 6; s++) begin
      bus(1'b1, REG_CTRL, (32'(s) << CTRL_STEP_LSB) | 32'h3);
      for (int j = 0; j < 6; j++) begin
        tab(8'(8 + j), 8'h00, gs[j]);
        idx <= {4{8'(8 + j)}};
        repeat (5) @(negedge clk);
        gc = (gs[j] > 7'd100) ? 7'd100 : gs[j];
        p  = (gc == 7'd0) ? 4'h0 : (gc / st[s] >= 7'd14) ? 4'hf : 4'(gc / st[s] + 7'd1);
        `CHK("lines", {4{p}}, gpio)
        `CHK("code", p, code[3])
      end
    end
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("status", {16'h0, {4{p}}}, q)
  endtask : t_slice
  task automatic t_lines;
    logic [23:0] e [4];
    e = '{24'hffc000, 24'hffe000, 24'h000800, 24'h0021e5};
    tab(8'h04, 8'h00, 7'd0);
    tab(8'h05, 8'h00, 7'd12);
    tab(8'h06, 8'h00, 7'd24);
    tab(8'h07, 8'h00, 7'd1);
    bus(1'b1, REG_CTRL, 32'h43);
    bus(1'b1, REG_MAN_INDEX, 32'h07060504);
    bus(1'b1, REG_GAIN_SRC, 32'hf);
    repeat (5) @(negedge clk);
    `CHK("lines", 16'h2031, gpio)
    send({16'h4000, 16'h1000, 16'hc000, 16'hc000});
    for (int r = 0; r < 4; r++) `CHK("word", e[r], word[r])
    bus(1'b1, REG_GPIO_CFG, 32'hf000_00ff);
    repeat (5) @(negedge clk);
    `CHK("masked", 16'h2000, gpio)
    `CHK("oe", 16'h00ff, oe)
  endtask : t_lines
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_nocomp();
    t_slice();
    t_lines();
    give_verdict();
  end
endmodule : tb_rxgc_top
